/* File: design/pdcg_regs.svh */
`ifndef PDCG_REGS_SVH
`define PDCG_REGS_SVH

// Register byte addresses
`define PDCG_ADDR_PWR_CTRL       8'h00
`define PDCG_ADDR_AHB_GATES      8'h04
`define PDCG_ADDR_APB_GATES      8'h08
`define PDCG_ADDR_CLK_MONITOR    8'h0C
`define PDCG_ADDR_PROT_KEY       8'h10

// Power-down control fields
`define PDCG_BIT_WAIT_CPU        8
`define PDCG_BIT_PD_REQ          7
`define PDCG_BIT_WAKE_FLAG       6
`define PDCG_BIT_WAKE_IRQ_EN     5
`define PDCG_BIT_WAKE_DLY_EN     4
`define PDCG_BIT_LIRC_EN         3
`define PDCG_BIT_HIRC_EN         2
`define PDCG_BIT_HXT_EN          0

// Clock monitor fields
`define PDCG_BIT_SW_FAIL         7
`define PDCG_BIT_HIRC_STB        4
`define PDCG_BIT_LIRC_STB        3
`define PDCG_BIT_PLL_LOCKED_FLAG         2
`define PDCG_BIT_HXT_STB         0

// Gate fields and masks
`define PDCG_BIT_FLASH_PROG      2
`define PDCG_BIT_DMA             1
`define PDCG_BIT_WDOG            0
`define PDCG_AHB_WR_MASK         32'h0000_0006
`define PDCG_APB_WR_MASK         32'hB833_737D
`define PDCG_APB_PD_KEEP_MASK    32'h0030_003D

// Reset values
`define PDCG_RST_AHB             32'h0000_000D
`define PDCG_RST_APB             32'h0000_0001
`define PDCG_RST_WAKE_DLY_EN     1'b1
`define PDCG_RST_LIRC_EN         1'b0
`define PDCG_RST_HIRC_EN         1'b1
`define PDCG_CFG_SRC_HXT         3'h0

// Unlock key sequence
`define PDCG_KEY_1               8'h59
`define PDCG_KEY_2               8'h16
`define PDCG_KEY_3               8'h88

// Wake-up delay counts
`define PDCG_DLY_HXT_CYC         13'h1000
`define PDCG_DLY_HIRC_CYC        13'h0100

// AXI responses
`define PDCG_RESP_OKAY           2'h0
`define PDCG_RESP_SLVERR         2'h2

`endif

/* File: design/pdcg_pkg.sv */
`default_nettype none
package pdcg_pkg;
   typedef enum logic [1:0] {
      PDCG_RUN,
      PDCG_POWER_DOWN,
      PDCG_WAKE_DELAY
   } pdcg_state_type;
endpackage
`default_nettype wire

/* File: design/pdcg_top.sv */
// Summary of operation
// [R1] Control bits except flag need key unlock
// [R2] Wait-for-CPU set: enter after request and sleep
// [R3] Wait-for-CPU clear: enter on request alone
// [R4] Wake-up clears power-down request by hardware
// [R5] Power-down stops crystal and fast oscillator
// [R6] Power-down stops PLL and system clock
// [R7] Wake sets flag when enabled; write-1 clears
// [R8] Interrupt when flag and enable both high
// [R9] Wake delay: 4096 crystal, 256 fast cycles
// [R10] Separate enables for three oscillators
// [R11] Crystal enable reset from config word
// [R12] Sleep without power-down gates CPU clock only; the code gates it only while wait-for-CPU is clear
// [R13] Power-down keeps watchdog, timer, PWM clocks
// [R14] Software enables wake sources before request
// [R15] AHB gates: flash programming bit2, DMA bit1
// [R16] APB gates one bit per peripheral
// [R17] Watchdog gate writable only when unlocked
// [R18] Monitor shows switch failure and stability bits
// [R19] Switch failure updated per switch; write-1 clears
// [R20] Wrong key, order or address aborts unlock
// [R21] Gates change only while gated clock low
//
// Our own choice: the AXI4-Lite slave port.
`include "pdcg_regs.svh"
`default_nettype none
module pdcg_top
   import pdcg_pkg::*;
(
   input  wire logic        I_CLK,
   input  wire logic        I_RST_N,
   input  wire logic [31:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [31:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        I_CPU_SLEEP,
   input  wire logic        I_WAKE_EVENT,
   input  wire logic [2:0]  I_USER_CONFIG_SRC,
   input  wire logic        I_SYSCLK_FROM_HXT,
   input  wire logic        I_CLK_SWITCH,
   input  wire logic        I_SWITCH_TARGET_STABLE,
   input  wire logic        I_HXT_STABLE,
   input  wire logic        I_HIRC_STABLE,
   input  wire logic        I_LIRC_STABLE,
   input  wire logic        I_PLL_LOCKED,
   output logic             O_HXT_EN,
   output logic             O_HIRC_EN,
   output logic             O_LIRC_EN,
   output logic             O_PLL_EN,
   output logic             O_SYSCLK_EN,
   output logic             O_CPU_CLK_EN,
   output logic             O_FLASH_PROG_CLK_EN,
   output logic             O_DMA_CLK_EN,
   output logic [31:0]      O_APB_CLK_EN,
   output logic             O_WAKE_IRQ,
   output logic             O_POWER_DOWN
);

   // ==========================================================
   // Helpers
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction
   function automatic logic addr_mapped(input logic [7:0] a);
      return (a == `PDCG_ADDR_PWR_CTRL) || (a == `PDCG_ADDR_AHB_GATES) ||
             (a == `PDCG_ADDR_APB_GATES) || (a == `PDCG_ADDR_CLK_MONITOR) ||
             (a == `PDCG_ADDR_PROT_KEY);
   endfunction

   // ==========================================================
   // State
   logic           aw_ready_q, w_ready_q, b_valid_q, ar_ready_q, r_valid_q;
   logic           aw_held_q, w_held_q;
   logic [7:0]     aw_addr_q;
   logic [31:0]    w_data_q;
   logic [3:0]     w_strb_q;
   logic [1:0]     b_resp_q, r_resp_q;
   logic [31:0]    r_data_q;
   logic           wait_cpu_q, pd_req_q, wake_flag_q, wake_irq_en_q;
   logic           wake_dly_en_q, lirc_en_q, hirc_en_q, hxt_en_q;
   logic [31:0]    ahb_q, apb_q;
   logic           sw_fail_q;
   logic [1:0]     key_seq_q;
   logic           unlocked_q;
   pdcg_state_type state_q, state_d;
   logic [12:0]    dly_cnt_q, dly_cnt_d;
   // ==========================================================
   // Register decode
   wire        wr_fire   = aw_held_q & w_held_q & ~b_valid_q;
   wire        wr_pwr    = wr_fire & (aw_addr_q == `PDCG_ADDR_PWR_CTRL);
   wire        wr_ahb    = wr_fire & (aw_addr_q == `PDCG_ADDR_AHB_GATES);
   wire        wr_apb    = wr_fire & (aw_addr_q == `PDCG_ADDR_APB_GATES);
   wire        wr_mon    = wr_fire & (aw_addr_q == `PDCG_ADDR_CLK_MONITOR);
   wire        wr_key    = wr_fire & (aw_addr_q == `PDCG_ADDR_PROT_KEY) & w_strb_q[0];
   wire [7:0]  key_byte  = w_data_q[7:0];
   wire [7:0]  ar_addr   = S_AXI_ARADDR[7:0];
   wire        ar_fire   = S_AXI_ARVALID & ar_ready_q;
   wire [31:0] pwr_rd = {23'h0, wait_cpu_q, pd_req_q, wake_flag_q, wake_irq_en_q,
                         wake_dly_en_q, lirc_en_q, hirc_en_q, 1'b0, hxt_en_q};
   wire [31:0] mon_rd = {24'h0, sw_fail_q, 2'h0, I_HIRC_STABLE, I_LIRC_STABLE,
                         I_PLL_LOCKED, 1'b0, I_HXT_STABLE}; // [R18]
   wire [31:0] pwr_new = merge_bytes(pwr_rd, w_data_q, w_strb_q);
   wire [31:0] ahb_new = merge_bytes(ahb_q, w_data_q, w_strb_q);
   wire [31:0] apb_new = merge_bytes(apb_q, w_data_q, w_strb_q);
   wire [31:0] mon_new = merge_bytes(32'h0, w_data_q, w_strb_q);
   wire        pwr_prot_wr = wr_pwr & unlocked_q; // [R1]
   wire [31:0] apb_wr_mask = unlocked_q ? `PDCG_APB_WR_MASK
                                        : (`PDCG_APB_WR_MASK & ~32'h0000_0001); // [R17]
   wire [31:0] rd_mux =
      (ar_addr == `PDCG_ADDR_PWR_CTRL)    ? pwr_rd :
      (ar_addr == `PDCG_ADDR_AHB_GATES)   ? ahb_q :
      (ar_addr == `PDCG_ADDR_APB_GATES)   ? apb_q :
      (ar_addr == `PDCG_ADDR_CLK_MONITOR) ? mon_rd :
      (ar_addr == `PDCG_ADDR_PROT_KEY)    ? {31'h0, unlocked_q} : 32'h0;
   // ==========================================================
   // AXI4-Lite handshakes
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         aw_ready_q <= 1'b1;
         w_ready_q  <= 1'b1;
         aw_held_q  <= 1'b0;
         w_held_q   <= 1'b0;
         aw_addr_q  <= 8'h00;
         w_data_q   <= 32'h0;
         w_strb_q   <= 4'h0;
         b_valid_q  <= 1'b0;
         b_resp_q   <= `PDCG_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && aw_ready_q) begin
            aw_ready_q <= 1'b0;
            aw_held_q  <= 1'b1;
            aw_addr_q  <= {S_AXI_AWADDR[7:2], 2'b00};
         end
         if (S_AXI_WVALID && w_ready_q) begin
            w_ready_q <= 1'b0;
            w_held_q  <= 1'b1;
            w_data_q  <= S_AXI_WDATA;
            w_strb_q  <= S_AXI_WSTRB;
         end
         if (wr_fire) begin
            b_valid_q <= 1'b1;
            b_resp_q  <= addr_mapped(aw_addr_q) ? `PDCG_RESP_OKAY : `PDCG_RESP_SLVERR;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
         end
         if (b_valid_q && S_AXI_BREADY) begin
            b_valid_q  <= 1'b0;
            aw_ready_q <= 1'b1;
            w_ready_q  <= 1'b1;
         end
      end
   end
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         ar_ready_q <= 1'b1;
         r_valid_q  <= 1'b0;
         r_data_q   <= 32'h0;
         r_resp_q   <= `PDCG_RESP_OKAY;
      end else if (ar_fire) begin
         ar_ready_q <= 1'b0;
         r_valid_q  <= 1'b1;
         r_data_q   <= rd_mux;
         r_resp_q   <= addr_mapped(ar_addr) ? `PDCG_RESP_OKAY : `PDCG_RESP_SLVERR;
      end else if (r_valid_q && S_AXI_RREADY) begin
         r_valid_q  <= 1'b0;
         ar_ready_q <= 1'b1;
      end
   end
   // ==========================================================
   // Write protection key
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         key_seq_q  <= 2'h0;
         unlocked_q <= 1'b0;
      end else if (wr_key && unlocked_q) begin
         unlocked_q <= 1'b0;
         key_seq_q  <= 2'h0;
      end else if (wr_key) begin
         if (key_seq_q == 2'h0 && key_byte == `PDCG_KEY_1) begin
            key_seq_q <= 2'h1;
         end else if (key_seq_q == 2'h1 && key_byte == `PDCG_KEY_2) begin
            key_seq_q <= 2'h2;
         end else if (key_seq_q == 2'h2 && key_byte == `PDCG_KEY_3) begin
            key_seq_q  <= 2'h0;
            unlocked_q <= 1'b1; // [R1]
         end else begin
            key_seq_q <= 2'h0; // [R20]
         end
      end else if (wr_fire) begin
         key_seq_q <= 2'h0; // [R20]
      end
   end

   // ==========================================================
   // Power-down sequencing
   wire enter_pd = pd_req_q & (~wait_cpu_q | I_CPU_SLEEP); // [R2] [R3]
   wire wake     = (state_q == PDCG_POWER_DOWN) & I_WAKE_EVENT;
   wire [12:0] dly_len = I_SYSCLK_FROM_HXT ? `PDCG_DLY_HXT_CYC : `PDCG_DLY_HIRC_CYC;
   always_comb begin
      state_d   = state_q;
      dly_cnt_d = dly_cnt_q;
      case (state_q)
         PDCG_RUN: begin
            if (enter_pd) begin
               state_d = PDCG_POWER_DOWN;
            end
         end
         PDCG_POWER_DOWN: begin
            if (I_WAKE_EVENT && wake_dly_en_q) begin
               state_d   = PDCG_WAKE_DELAY; // [R9]
               dly_cnt_d = dly_len - 13'h1;
            end else if (I_WAKE_EVENT) begin
               state_d = PDCG_RUN;
            end
         end
         PDCG_WAKE_DELAY: begin
            if (dly_cnt_q == 13'h0) begin
               state_d = PDCG_RUN;
            end else begin
               dly_cnt_d = dly_cnt_q - 13'h1; // [R9]
            end
         end
         default: begin
            state_d = PDCG_RUN;
         end
      endcase
   end
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         state_q   <= PDCG_RUN;
         dly_cnt_q <= 13'h0;
      end else begin
         state_q   <= state_d;
         dly_cnt_q <= dly_cnt_d;
      end
   end

   // ==========================================================
   // Control and status registers
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         wait_cpu_q    <= 1'b0;
         pd_req_q      <= 1'b0;
         wake_irq_en_q <= 1'b0;
         wake_dly_en_q <= `PDCG_RST_WAKE_DLY_EN;
         lirc_en_q     <= `PDCG_RST_LIRC_EN;
         hirc_en_q     <= `PDCG_RST_HIRC_EN;
         hxt_en_q      <= (I_USER_CONFIG_SRC == `PDCG_CFG_SRC_HXT); // [R11]
      end else begin
         if (pwr_prot_wr) begin // [R10]
            wait_cpu_q    <= pwr_new[`PDCG_BIT_WAIT_CPU];
            wake_irq_en_q <= pwr_new[`PDCG_BIT_WAKE_IRQ_EN];
            wake_dly_en_q <= pwr_new[`PDCG_BIT_WAKE_DLY_EN];
            lirc_en_q     <= pwr_new[`PDCG_BIT_LIRC_EN];
            hirc_en_q     <= pwr_new[`PDCG_BIT_HIRC_EN];
            hxt_en_q      <= pwr_new[`PDCG_BIT_HXT_EN];
         end
         if (wake) begin
            pd_req_q <= 1'b0; // [R4]
         end else if (pwr_prot_wr) begin
            pd_req_q <= pwr_new[`PDCG_BIT_PD_REQ];
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         wake_flag_q <= 1'b0;
      end else if (wake && wake_irq_en_q) begin
         wake_flag_q <= 1'b1; // [R7]
      end else if (wr_pwr && w_strb_q[0] && w_data_q[`PDCG_BIT_WAKE_FLAG]) begin
         wake_flag_q <= 1'b0; // [R7]
      end
   end
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         sw_fail_q <= 1'b0;
      end else if (I_CLK_SWITCH) begin
         sw_fail_q <= ~I_SWITCH_TARGET_STABLE; // [R19]
      end else if (wr_mon && mon_new[`PDCG_BIT_SW_FAIL]) begin
         sw_fail_q <= 1'b0; // [R19]
      end
   end
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         ahb_q <= `PDCG_RST_AHB;
         apb_q <= `PDCG_RST_APB;
      end else begin
         if (wr_ahb) begin
            ahb_q <= (ahb_q & ~`PDCG_AHB_WR_MASK) | (ahb_new & `PDCG_AHB_WR_MASK); // [R15]
         end
         if (wr_apb) begin
            apb_q <= (apb_q & ~apb_wr_mask) | (apb_new & apb_wr_mask); // [R16] [R17]
         end
      end
   end

   // ==========================================================
   // Clock enable outputs, all registered on the rising edge
   // Downstream latch gates sample them while the clock is low
   wire in_pd  = (state_q == PDCG_POWER_DOWN);
   wire in_dly = (state_q == PDCG_WAKE_DELAY);
   wire idle   = I_CPU_SLEEP & ~pd_req_q & ~wait_cpu_q;
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         O_HXT_EN            <= 1'b0;
         O_HIRC_EN           <= 1'b0;
         O_LIRC_EN           <= 1'b0;
         O_PLL_EN            <= 1'b0;
         O_SYSCLK_EN         <= 1'b0;
         O_CPU_CLK_EN        <= 1'b0;
         O_FLASH_PROG_CLK_EN <= 1'b0;
         O_DMA_CLK_EN        <= 1'b0;
         O_APB_CLK_EN        <= 32'h0;
         O_WAKE_IRQ          <= 1'b0;
         O_POWER_DOWN        <= 1'b0;
      end else begin // [R21]
         O_HXT_EN            <= hxt_en_q & ~in_pd; // [R5]
         O_HIRC_EN           <= hirc_en_q & ~in_pd; // [R5]
         O_LIRC_EN           <= lirc_en_q; // [R5]
         O_PLL_EN            <= ~in_pd; // [R6]
         O_SYSCLK_EN         <= ~in_pd & ~in_dly; // [R6] [R9]
         O_CPU_CLK_EN        <= ~in_pd & ~in_dly & ~idle; // [R12]
         O_FLASH_PROG_CLK_EN <= ahb_q[`PDCG_BIT_FLASH_PROG] & ~in_pd; // [R15]
         O_DMA_CLK_EN        <= ahb_q[`PDCG_BIT_DMA] & ~in_pd; // [R15]
         O_APB_CLK_EN        <= in_pd ? (apb_q & `PDCG_APB_PD_KEEP_MASK) : apb_q; // [R13]
         O_WAKE_IRQ          <= wake_flag_q & wake_irq_en_q; // [R8]
         O_POWER_DOWN        <= in_pd;
      end
   end

   assign S_AXI_AWREADY = aw_ready_q;
   assign S_AXI_WREADY  = w_ready_q;
   assign S_AXI_BVALID  = b_valid_q;
   assign S_AXI_BRESP   = b_resp_q;
   assign S_AXI_ARREADY = ar_ready_q;
   assign S_AXI_RVALID  = r_valid_q;
   assign S_AXI_RDATA   = r_data_q;
   assign S_AXI_RRESP   = r_resp_q;
   // ==========================================================
   // Assertions
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);
   sequence s_wake_delayed;
      state_q == PDCG_POWER_DOWN && I_WAKE_EVENT && wake_dly_en_q && !I_SYSCLK_FROM_HXT;
   endsequence
   sequence s_clock_held;
      !O_SYSCLK_EN [*8];
   endsequence
   AST_LOCKED_PWR: assert property (wr_pwr && !unlocked_q && !wake |=> // [R1]
      $stable({wait_cpu_q, pd_req_q, wake_irq_en_q, wake_dly_en_q, lirc_en_q, hxt_en_q, hirc_en_q}))
      else $error("locked power control changed");
   AST_WAIT_CPU: assert property (state_q == PDCG_RUN && pd_req_q && wait_cpu_q && !I_CPU_SLEEP // [R2]
      |=> state_q == PDCG_RUN)
      else $error("entered power-down without CPU sleep");
   AST_NO_WAIT: assert property (state_q == PDCG_RUN && pd_req_q && !wait_cpu_q // [R3]
      |=> state_q == PDCG_POWER_DOWN ##1 O_POWER_DOWN)
      else $error("power-down entry missed");
   AST_WAKE_CLEAR: assert property (wake |=> !pd_req_q) // [R4]
      else $error("request not cleared on wake");
   AST_OSC_OFF: assert property (in_pd |=> !O_HXT_EN && !O_HIRC_EN && O_LIRC_EN == $past(lirc_en_q)) // [R5]
      else $error("oscillators wrong in power-down");
   AST_SYS_OFF: assert property (in_pd |=> !O_PLL_EN && !O_SYSCLK_EN && !O_CPU_CLK_EN) // [R6]
      else $error("system clock running in power-down");
   AST_FLAG_SET: assert property (wake && wake_irq_en_q |=> wake_flag_q ##1 O_WAKE_IRQ) // [R7]
      else $error("wake flag or interrupt missing");
   AST_WAKE_DLY: assert property (s_wake_delayed |=> ##1 s_clock_held ##[240:260] O_SYSCLK_EN) // [R9]
      else $error("wake delay length wrong");
   AST_PD_GATES: assert property (in_pd |=> (O_APB_CLK_EN & ~`PDCG_APB_PD_KEEP_MASK) == 32'h0) // [R13]
      else $error("peripheral clock left on in power-down");
   AST_SW_FAIL: assert property (I_CLK_SWITCH |=> sw_fail_q == !$past(I_SWITCH_TARGET_STABLE)) // [R19]
      else $error("switch failure flag wrong");
   AST_KEY_ABORT: assert property (wr_fire && !wr_key && key_seq_q != 2'h0 |=> key_seq_q == 2'h0) // [R20]
      else $error("unlock not aborted");
endmodule
`default_nettype wire

/* File: dv/pdcg_cpu_model.sv */
`default_nettype none
module pdcg_cpu_model (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_sleep_cmd,
   input  wire logic i_wake_cmd,
   input  wire logic i_slow,
   output logic      o_cpu_sleep,
   output logic      o_wake_event
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;
   logic       armed_q;
   // ==========
   // Sleep held until the wake event fires
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_cpu_sleep <= 1'b0;
         o_wake_event <= 1'b0;
         cnt_q <= 4'h0;
         armed_q <= 1'b0;
      end else begin
         o_wake_event <= 1'b0;
         if (i_sleep_cmd)
            o_cpu_sleep <= 1'b1;
         if (i_wake_cmd) begin
            armed_q <= 1'b1;
            cnt_q <= i_slow ? 4'hF : 4'h0;
         end else if (armed_q && cnt_q == 4'h0) begin
            o_wake_event <= 1'b1;
            o_cpu_sleep <= 1'b0;
            armed_q <= 1'b0;
         end else if (armed_q) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: dv/power_down_and_clock_gating_test.sv */
`default_nettype none
module power_down_and_clock_gating_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        I_CLK = 1'b0;
   logic        I_RST_N = 1'b0;
   logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA, O_APB_CLK_EN, rd;
   logic [3:0]  S_AXI_WSTRB;
   logic [2:0]  I_USER_CONFIG_SRC;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rs;
   logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
   logic        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, I_CPU_SLEEP, I_WAKE_EVENT;
   logic        I_SYSCLK_FROM_HXT, I_CLK_SWITCH, I_SWITCH_TARGET_STABLE, I_HXT_STABLE, I_HIRC_STABLE;
   logic        I_LIRC_STABLE, I_PLL_LOCKED, O_HXT_EN, O_HIRC_EN, O_LIRC_EN, O_PLL_EN, O_SYSCLK_EN;
   logic        O_CPU_CLK_EN, O_FLASH_PROG_CLK_EN, O_DMA_CLK_EN, O_WAKE_IRQ, O_POWER_DOWN;
   logic        sleep_cmd, wake_cmd, slow;
   int          err_count, tests_run;

   pdcg_top dut_u (.I_CLK, .I_RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
      .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
      .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
      .S_AXI_RREADY, .I_CPU_SLEEP, .I_WAKE_EVENT, .I_USER_CONFIG_SRC, .I_SYSCLK_FROM_HXT, .I_CLK_SWITCH,
      .I_SWITCH_TARGET_STABLE, .I_HXT_STABLE, .I_HIRC_STABLE, .I_LIRC_STABLE, .I_PLL_LOCKED, .O_HXT_EN,
      .O_HIRC_EN, .O_LIRC_EN, .O_PLL_EN, .O_SYSCLK_EN, .O_CPU_CLK_EN, .O_FLASH_PROG_CLK_EN,
      .O_DMA_CLK_EN, .O_APB_CLK_EN, .O_WAKE_IRQ, .O_POWER_DOWN);
   pdcg_cpu_model cpu_u (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_sleep_cmd(sleep_cmd), .i_wake_cmd(wake_cmd),
      .i_slow(slow), .o_cpu_sleep(I_CPU_SLEEP), .o_wake_event(I_WAKE_EVENT));

   always #50 I_CLK = ~I_CLK;

   // ==========
   // Common tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge I_CLK);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge I_CLK);
      S_AXI_AWADDR <= {24'h0, a};
      S_AXI_WDATA <= d;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
      do begin
         @(posedge I_CLK);
         if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1);
      rs = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge I_CLK);
      S_AXI_ARADDR <= {24'h0, a};
      {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
      do begin
         @(posedge I_CLK);
         if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1);
      rd = S_AXI_RDATA;
      rs = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
      chk(nm, rd, exp);
   endtask
   task automatic key(input logic [7:0] k3);
      wr(8'h10, 32'h59);
      wr(8'h10, 32'h16);
      wr(8'h10, {24'h0, k3});
   endtask
   task automatic cmd(input logic s, input logic w, input logic sl);
      @(posedge I_CLK);
      {sleep_cmd, wake_cmd, slow} <= {s, w, sl};
      @(posedge I_CLK);
      {sleep_cmd, wake_cmd} <= 2'h0;
   endtask
   task automatic sw(input logic st);
      @(posedge I_CLK);
      {I_CLK_SWITCH, I_SWITCH_TARGET_STABLE} <= {1'b1, st};
      @(posedge I_CLK);
      I_CLK_SWITCH <= 1'b0;
   endtask

   // ==========
   // Scenarios
   task automatic t_reset;
      rc(8'h00, 32'h15, "ctrl reset");
      rc(8'h04, 32'hD, "ahb reset");
      rc(8'h10, 32'h0, "key reset");
      chk("osc enables", {O_HXT_EN, O_HIRC_EN, O_LIRC_EN}, 3'h6);
   endtask
   task automatic t_protect;
      wr(8'h00, 32'h0);
      rc(8'h00, 32'h15, "locked ctrl");
      wr(8'h08, 32'h0);
      rc(8'h08, 32'h1, "locked wdog gate");
      wr(8'h08, 32'hFFFF_FFFF);
      rc(8'h08, 32'hB833_737D, "apb gates");
      key(8'h77);
      rc(8'h10, 32'h0, "bad key");
      wr(8'h10, 32'h59);
      wr(8'h14, 32'hFFFF_FFFF);
      chk("unmapped write", rs, 2'h2);
      wr(8'h10, 32'h16);
      wr(8'h10, 32'h88);
      rc(8'h10, 32'h0, "broken key");
      rc(8'h14, 32'h0, "unmapped read");
      chk("unmapped resp", rs, 2'h2);
      key(8'h88);
      rc(8'h10, 32'h1, "unlocked");
      wr(8'h08, 32'h0);
      rc(8'h08, 32'h0, "open wdog gate");
      chk("apb out", O_APB_CLK_EN, 32'h0);
      wr(8'h08, 32'hFFFF_FFFF);
      wr(8'h00, 32'hD);
      rc(8'h00, 32'hD, "ctrl write");
      chk("lirc on", O_LIRC_EN, 1'b1);
   endtask
   task automatic t_ahb;
      wr(8'h04, 32'h0);
      rc(8'h04, 32'h9, "ahb off");
      wr(8'h04, 32'h2);
      cyc(2);
      chk("ahb out", {O_FLASH_PROG_CLK_EN, O_DMA_CLK_EN}, 2'h1);
      wr(8'h04, 32'h6);
   endtask
   task automatic t_idle;
      cmd(1'b1, 1'b0, 1'b0);
      cyc(3);
      chk("idle", {O_CPU_CLK_EN, O_SYSCLK_EN, O_POWER_DOWN}, 3'h2);
      cmd(1'b0, 1'b1, 1'b0);
      cyc(4);
      chk("idle exit", O_CPU_CLK_EN, 1'b1);
   endtask
   task automatic t_pd_now;
      wr(8'h00, 32'h2D);
      wr(8'h00, 32'hAD);
      cyc(3);
      chk("pd", O_POWER_DOWN, 1'b1);
      chk("pd osc", {O_HXT_EN, O_HIRC_EN, O_LIRC_EN}, 3'h1);
      chk("pd sys", {O_PLL_EN, O_SYSCLK_EN, O_CPU_CLK_EN}, 3'h0);
      chk("pd apb", O_APB_CLK_EN, 32'h0030_003D);
      cmd(1'b0, 1'b1, 1'b0);
      cyc(4);
      chk("woke", {O_POWER_DOWN, O_WAKE_IRQ, O_SYSCLK_EN}, 3'h3);
      rc(8'h00, 32'h6D, "wake ctrl");
      wr(8'h00, 32'h6D);
      cyc(2);
      chk("irq clr", O_WAKE_IRQ, 1'b0);
   endtask
   task automatic t_pd_wait;
      wr(8'h00, 32'h18D);
      cyc(10);
      chk("wait cpu", O_POWER_DOWN, 1'b0);
      cmd(1'b1, 1'b0, 1'b0);
      cyc(3);
      chk("cpu slept", O_POWER_DOWN, 1'b1);
      chk("pd apb", O_APB_CLK_EN, 32'h0030_003D);
      cmd(1'b0, 1'b1, 1'b1);
      cyc(20);
      chk("slow wake", {O_POWER_DOWN, O_WAKE_IRQ}, 2'h0);
      rc(8'h00, 32'h10D, "no flag");
   endtask
   task automatic t_delay(input logic hxt, input int n);
      @(posedge I_CLK);
      I_SYSCLK_FROM_HXT <= hxt;
      wr(8'h00, 32'h9D);
      cyc(3);
      cmd(1'b0, 1'b1, 1'b0);
      cyc(n - 8);
      chk("delay hold", O_SYSCLK_EN, 1'b0);
      cyc(16);
      chk("delay end", O_SYSCLK_EN, 1'b1);
   endtask
   task automatic t_monitor;
      @(posedge I_CLK);
      {I_HXT_STABLE, I_HIRC_STABLE, I_LIRC_STABLE, I_PLL_LOCKED} <= 4'hD;
      sw(1'b0);
      rc(8'h0C, 32'h95, "switch fail");
      wr(8'h0C, 32'h80);
      rc(8'h0C, 32'h15, "fail clr");
      sw(1'b0);
      sw(1'b1);
      rc(8'h0C, 32'h15, "switch ok");
   endtask
   // Mid-run reset with a non-crystal config, then wake flag cleared while locked
   task automatic t_cfg;
      @(posedge I_CLK);
      {I_RST_N, I_USER_CONFIG_SRC} <= {1'b0, 3'h7};
      repeat (3) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      cyc(1);
      rc(8'h00, 32'h14, "cfg ctrl");
      chk("cfg hxt", O_HXT_EN, 1'b0);
      key(8'h88);
      wr(8'h00, 32'hA0);
      wr(8'h10, 32'h0);
      cmd(1'b0, 1'b1, 1'b0);
      cyc(4);
      rc(8'h00, 32'h60, "locked flag");
      wr(8'h00, 32'h40);
      rc(8'h00, 32'h20, "locked clear");
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==========
   // Main sequence
   initial begin
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
      {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR} = 96'h0;
      S_AXI_WSTRB = 4'hF;
      I_USER_CONFIG_SRC = 3'h0;
      {I_SYSCLK_FROM_HXT, I_CLK_SWITCH, I_SWITCH_TARGET_STABLE, I_HXT_STABLE} = 4'h0;
      {I_HIRC_STABLE, I_LIRC_STABLE, I_PLL_LOCKED, sleep_cmd, wake_cmd, slow} = 6'h0;
      err_count = 0;
      tests_run = 0;
      repeat (3) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      cyc(1);
      t_reset;
      t_protect;
      t_ahb;
      t_idle;
      t_pd_now;
      t_pd_wait;
      t_delay(1'b0, 256);
      t_delay(1'b1, 4096);
      t_monitor;
      t_cfg;
      close_out;
   end
   initial begin
      #2_000_000;
      err_count++;
      close_out;
   end
endmodule
`default_nettype wire
